/* File: logic/glu_pkg.sv */
// Constants, encodings and state types shared by the glue logic unit files
// Functional notes
// - Protected pair configuration writes are ignored while the pair's even table is enabled.
// - Protected: sequencer select and all table control fields except table enable.
// - Even table write setting enable also loads protected fields; write clearing enable does not.
// - Global enable bit activates the whole block; zero deactivates it.
// - Each table has its own enable bit, one activates, zero deactivates.
// - Table output is truth bit indexed by inputs 2,1,0, input 2 most significant.
// - Inputs 0 and 1 selected in second control register, input 2 in third.
// - A masked input reads as constant low.
// - Feedback source gives sequencer N output to tables 2N and 2N+1.
// - Linked source gives table n the output of table n+1, last gets table 0.
// - Two asynchronous event lines are selectable as table inputs.
// - Pin source follows the dedicated input pin of same table and index.
// - Synchronizer option delays the table output by two table-clock edges.
// - Filter passes only values steady over three edges, four edges of lag.
// - Synchronizer and filter state clear one cycle after the table is disabled.
// - Edge detector gives a pulse on each rising edge of its input when enabled.
// - Edge detector state clears one cycle after the table is disabled.
// - Sequencer takes the configured path outputs and runs on the even table clock.
// - Flops update on rising edge; even table disable clears latch and flop.
// - Gated D flop: even is D, odd is gate; gate high loads, low holds.
// - JK flop: even J, odd K; 00 hold, 01 clear, 10 set, 11 toggle.
// - Sequencer codes: 0 off, 1 D flop, 2 JK, 3 D latch, 4 RS latch.
// - Filter codes: 0 none, 1 synchronizer, 2 glitch filter, 3 reserved.
// - Clock-source bit makes input 2 the table clock and low in the truth table.
// - D latch follows D while gate high; RS latch: set even, reset odd.
package glu_pkg;
  localparam int NUM_TABLES = 2;
  localparam int PIN_COUNT = 6;
  localparam int PERIPH_COUNT = 8;

  // Register offsets, byte addressed on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SEQ = 4'h1;
  localparam logic [3:0] ADDR_TBL_BASE = 4'h5;
  localparam logic [3:0] ADDR_TBL_STRIDE = 4'h4;
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_CTRL_C = 4'h2;
  localparam logic [3:0] OFS_TRUTH = 4'h3;

  // Field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RUNSTDBY = 6;
  localparam int BIT_OUTEN = 3;
  localparam int FILT_LSB = 4;
  localparam int BIT_TABLE_CLOCK_SOURCE = 6;
  localparam int BIT_EDGE_DETECT_ENABLE = 7;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Sequencer function codes
  localparam logic [3:0] SEQ_OFF = 4'h0;
  localparam logic [3:0] SEQ_DFF = 4'h1;
  localparam logic [3:0] SEQ_JK = 4'h2;
  localparam logic [3:0] SEQ_DLATCH = 4'h3;
  localparam logic [3:0] SEQ_RSLATCH = 4'h4;

  // Output filter codes
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_SYNC = 2'h1;
  localparam logic [1:0] FILT_GLITCH = 2'h2;

  // Input source codes; peripheral inputs occupy 6..13, 14 and 15 read low
  localparam logic [3:0] SRC_MASK = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK = 4'h2;
  localparam logic [3:0] SRC_EVENT_A = 4'h3;
  localparam logic [3:0] SRC_EVENT_B = 4'h4;
  localparam logic [3:0] SRC_PIN = 4'h5;
  localparam logic [3:0] SRC_PERIPH_BASE = 4'h6;
  localparam logic [3:0] SRC_PERIPH_LAST = 4'hd;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } glu_reg_req_t;

  typedef struct packed {
    logic edge_detect_enable;
    logic table_clock_source;
    logic [1:0] output_filter_select;
    logic outEn;
    logic en;
    logic [3:0] input2_source_select;
    logic [3:0] input1_source_select;
    logic [3:0] input0_source_select;
    logic [7:0] truth;
  } glu_table_cfg_t;

  typedef struct packed {
    glu_table_cfg_t [NUM_TABLES-1:0] tbl;
    logic glbEn;
    logic runStdby;
    logic [3:0] sequencer_function_select;
    logic [7:0] rdData;
    logic [PIN_COUNT-1:0] pinS1;
    logic [PIN_COUNT-1:0] pinS2;
    logic [1:0] evS1;
    logic [1:0] evS2;
    logic [NUM_TABLES-1:0] in2Prev;
    logic seqQ;
    logic [NUM_TABLES-1:0] outQ;
    logic [NUM_TABLES-1:0] outEnQ;
  } glu_state_t;

  typedef struct packed {
    logic syncA;
    logic syncB;
    logic stC;
    logic filtQ;
    logic edgePrev;
    logic pulse;
  } glu_path_state_t;
endpackage

/* File: logic/glu_out_path.sv */
// Per-table synchronizer, glitch filter and edge detector
`timescale 1ns/10ps
module glu_out_path (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tableEn,
  input wire logic tick,
  input wire logic [1:0] output_filter_select,
  input wire logic edge_detect_enable,
  input wire logic lutIn,
  output logic pathOut
);
  glu_pkg::glu_path_state_t q, d;
  logic pre;

  // Filter selection; the reserved code falls back to the raw table value
  always_comb begin
    if (output_filter_select == glu_pkg::FILT_SYNC) begin
      pre = q.syncB;
    end else if (output_filter_select == glu_pkg::FILT_GLITCH) begin
      pre = q.filtQ;
    end else begin
      pre = lutIn;
    end
    pathOut = edge_detect_enable ? q.pulse : pre;
  end

  // Stages advance only on table-clock ticks, so the pulse spans one table clock
  always_comb begin
    d = q;
    if (!tableEn) begin
      d = '0;
    end else if (tick) begin
      d.syncA = lutIn;
      d.syncB = q.syncA;
      d.stC = q.syncB;
      // Three equal samples needed, so a two-edge glitch never reaches filtQ
      if (q.syncA == q.syncB && q.syncB == q.stC) begin
        d.filtQ = q.stC;
      end
      d.edgePrev = pre;
      d.pulse = pre & ~q.edgePrev;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  path_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !tableEn |=> (q == '0))
    else $error("path state not cleared after disable");

  sync_lag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tableEn && tick && output_filter_select == glu_pkg::FILT_SYNC && !edge_detect_enable)[*3]
      |-> pathOut == $past(lutIn, 2))
    else $error("synchronizer lag is not two edges");

  pulse_once_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (tableEn && tick && q.pulse) ##1 (tableEn && tick) |-> !q.pulse)
    else $error("edge pulse longer than one table clock");

  filt_cover_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    tableEn && output_filter_select == glu_pkg::FILT_GLITCH && $rose(q.filtQ));
endmodule

/* File: logic/glu_logic_unit.sv */
// Glue logic unit: two three-input tables, pair sequencer and register port
`timescale 1ns/10ps
module glu_logic_unit (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire glu_pkg::glu_reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic [glu_pkg::PIN_COUNT-1:0] tableInputPin,
  input wire logic eventLineA,
  input wire logic eventLineB,
  input wire logic [glu_pkg::PERIPH_COUNT-1:0] periphIn,
  output logic [glu_pkg::NUM_TABLES-1:0] tableOut,
  output logic [glu_pkg::NUM_TABLES-1:0] tableOutEn,
  output logic seqOut
);
  localparam int NT = glu_pkg::NUM_TABLES;

  glu_pkg::glu_state_t q, d;
  logic [NT-1:0] te;
  logic [NT-1:0] tick;
  logic [NT-1:0] prelimLut;
  logic [NT-1:0] lutVal;
  logic [NT-1:0] pathOut;
  logic [NT-1:0][2:0] selIn;
  logic [NT-1:0][2:0] prelimIn;

  // Source mux for one table input; unused codes read low
  function automatic logic srcVal(input logic [3:0] code, input logic fb,
                                  input logic lnk, input logic pin,
                                  input logic [1:0] ev,
                                  input logic [glu_pkg::PERIPH_COUNT-1:0] per);
    logic v;
    v = 1'b0;
    if (code == glu_pkg::SRC_FEEDBACK) begin
      v = fb;
    end else if (code == glu_pkg::SRC_LINK) begin
      v = lnk;
    end else if (code == glu_pkg::SRC_EVENT_A) begin
      v = ev[0];
    end else if (code == glu_pkg::SRC_EVENT_B) begin
      v = ev[1];
    end else if (code == glu_pkg::SRC_PIN) begin
      v = pin;
    end else if (code >= glu_pkg::SRC_PERIPH_BASE && code <= glu_pkg::SRC_PERIPH_LAST) begin
      v = per[3'(code - glu_pkg::SRC_PERIPH_BASE)];
    end
    return v;
  endfunction

  // Truth lookup; the clock-source bit forces input 2 low in the index
  function automatic logic lookup(input glu_pkg::glu_table_cfg_t c,
                                  input logic [2:0] ins);
    logic [2:0] idx;
    idx = {ins[2] & ~c.table_clock_source, ins[1], ins[0]};
    return c.truth[idx];
  endfunction

  // Table datapath. Link inputs see a first pass in which links read low,
  // so two tables linked to each other never form a combinational loop.
  always_comb begin
    logic [3:0] code;
    logic lnk;
    code = '0;
    lnk = 1'b0;
    te = '0;
    tick = '0;
    selIn = '0;
    prelimIn = '0;
    prelimLut = '0;
    lutVal = '0;
    for (int n = 0; n < NT; n++) begin
      te[n] = q.glbEn & q.tbl[n].en;
      for (int i = 0; i < 3; i++) begin
        code = (i == 0) ? q.tbl[n].input0_source_select :
               (i == 1) ? q.tbl[n].input1_source_select : q.tbl[n].input2_source_select;
        prelimIn[n][i] = srcVal(code, q.seqQ, 1'b0, q.pinS2[n*3+i], q.evS2, periphIn);
      end
      prelimLut[n] = lookup(q.tbl[n], prelimIn[n]);
    end
    for (int n = 0; n < NT; n++) begin
      lnk = prelimLut[(n + 1) % NT];
      for (int i = 0; i < 3; i++) begin
        code = (i == 0) ? q.tbl[n].input0_source_select :
               (i == 1) ? q.tbl[n].input1_source_select : q.tbl[n].input2_source_select;
        // One sequencer per pair, so both tables see the same feedback
        selIn[n][i] = srcVal(code, q.seqQ, lnk, q.pinS2[n*3+i], q.evS2, periphIn);
      end
      lutVal[n] = te[n] & lookup(q.tbl[n], selIn[n]);
      // Rising edge of input 2 stands in for the table clock when selected
      tick[n] = q.tbl[n].table_clock_source ? (selIn[n][2] & ~q.in2Prev[n]) : 1'b1;
    end
  end

  // Filter and edge detector per table
  for (genvar g = 0; g < NT; g++) begin : gPath
    glu_out_path uPath (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .tableEn(te[g]),
      .tick(tick[g]),
      .output_filter_select(q.tbl[g].output_filter_select),
      .edge_detect_enable(q.tbl[g].edge_detect_enable),
      .lutIn(lutVal[g]),
      .pathOut(pathOut[g])
    );
  end

  // Next state: register port, input synchronizers, sequencer, outputs
  always_comb begin
    logic [3:0] tBase;
    logic protOk;
    logic [7:0] wdat;
    logic a;
    logic b;
    tBase = '0;
    protOk = 1'b0;
    wdat = regReq.wrData;
    a = pathOut[0];
    b = pathOut[1];
    d = q;
    d.pinS1 = tableInputPin;
    d.pinS2 = q.pinS1;
    d.evS1 = {eventLineB, eventLineA};
    d.evS2 = q.evS1;
    for (int n = 0; n < NT; n++) begin
      d.in2Prev[n] = selIn[n][2];
    end

    // Writes; protected fields of a pair are locked while its even table is enabled
    if (regReq.wr) begin
      if (regReq.addr == glu_pkg::ADDR_CTRL) begin
        d.glbEn = wdat[glu_pkg::BIT_ENABLE];
        d.runStdby = wdat[glu_pkg::BIT_RUNSTDBY];
      end else if (regReq.addr == glu_pkg::ADDR_SEQ) begin
        if (!q.tbl[0].en) begin
          d.sequencer_function_select = wdat[3:0];
        end
      end
      for (int n = 0; n < NT; n++) begin
        tBase = 4'(glu_pkg::ADDR_TBL_BASE + n * glu_pkg::ADDR_TBL_STRIDE);
        protOk = !q.tbl[(n / 2) * 2].en;
        if (regReq.addr == tBase + glu_pkg::OFS_CTRL_A) begin
          d.tbl[n].en = wdat[glu_pkg::BIT_ENABLE];
          // Old enable gates the fields: enable-and-configure works in one
          // write, disable-and-configure does not
          if (protOk) begin
            d.tbl[n].edge_detect_enable = wdat[glu_pkg::BIT_EDGE_DETECT_ENABLE];
            d.tbl[n].table_clock_source = wdat[glu_pkg::BIT_TABLE_CLOCK_SOURCE];
            d.tbl[n].output_filter_select = wdat[glu_pkg::FILT_LSB +: 2];
            d.tbl[n].outEn = wdat[glu_pkg::BIT_OUTEN];
          end
        end else if (regReq.addr == tBase + glu_pkg::OFS_CTRL_B) begin
          if (protOk) begin
            d.tbl[n].input0_source_select = wdat[glu_pkg::SEL0_LSB +: 4];
            d.tbl[n].input1_source_select = wdat[glu_pkg::SEL1_LSB +: 4];
          end
        end else if (regReq.addr == tBase + glu_pkg::OFS_CTRL_C) begin
          if (protOk) begin
            d.tbl[n].input2_source_select = wdat[3:0];
          end
        end else if (regReq.addr == tBase + glu_pkg::OFS_TRUTH) begin
          d.tbl[n].truth = wdat;
        end
      end
    end

    // Reads; data stand for exactly one cycle, unmapped offsets read zero
    d.rdData = glu_pkg::RESET_BYTE;
    if (regReq.rd) begin
      if (regReq.addr == glu_pkg::ADDR_CTRL) begin
        d.rdData = {1'b0, q.runStdby, 5'h00, q.glbEn};
      end else if (regReq.addr == glu_pkg::ADDR_SEQ) begin
        d.rdData = {4'h0, q.sequencer_function_select};
      end
      for (int n = 0; n < NT; n++) begin
        tBase = 4'(glu_pkg::ADDR_TBL_BASE + n * glu_pkg::ADDR_TBL_STRIDE);
        if (regReq.addr == tBase + glu_pkg::OFS_CTRL_A) begin
          d.rdData = {q.tbl[n].edge_detect_enable, q.tbl[n].table_clock_source, q.tbl[n].output_filter_select,
                      q.tbl[n].outEn, 2'h0, q.tbl[n].en};
        end else if (regReq.addr == tBase + glu_pkg::OFS_CTRL_B) begin
          d.rdData = {q.tbl[n].input1_source_select, q.tbl[n].input0_source_select};
        end else if (regReq.addr == tBase + glu_pkg::OFS_CTRL_C) begin
          d.rdData = {4'h0, q.tbl[n].input2_source_select};
        end else if (regReq.addr == tBase + glu_pkg::OFS_TRUTH) begin
          d.rdData = q.tbl[n].truth;
        end
      end
    end

    // Sequencer on the even table clock; latches track every system cycle
    if (!te[0]) begin
      d.seqQ = 1'b0;
    end else begin
      unique case (q.sequencer_function_select)
        glu_pkg::SEQ_DFF: begin
          if (tick[0] && b) begin
            d.seqQ = a;
          end
        end
        glu_pkg::SEQ_JK: begin
          if (tick[0]) begin
            unique case ({a, b})
              2'b01: d.seqQ = 1'b0;
              2'b10: d.seqQ = 1'b1;
              2'b11: d.seqQ = ~q.seqQ;
              default: d.seqQ = q.seqQ;
            endcase
          end
        end
        glu_pkg::SEQ_DLATCH: begin
          if (b) begin
            d.seqQ = a;
          end
        end
        glu_pkg::SEQ_RSLATCH: begin
          // Forbidden 11 holds the present value rather than racing
          if (a && !b) begin
            d.seqQ = 1'b1;
          end else if (!a && b) begin
            d.seqQ = 1'b0;
          end
        end
        default: d.seqQ = 1'b0;
      endcase
    end

    // Registered outputs add one system cycle after the table path
    for (int n = 0; n < NT; n++) begin
      d.outQ[n] = te[n] & pathOut[n];
      d.outEnQ[n] = te[n] & q.tbl[n].outEn;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign regRdData = q.rdData;
  assign tableOut = q.outQ;
  assign tableOutEn = q.outEnQ;
  assign seqOut = q.seqQ;

  locked_select_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == 4'h6 && q.tbl[0].en |=> $stable(q.tbl[0].input0_source_select))
    else $error("protected select changed while enabled");

  locked_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == glu_pkg::ADDR_SEQ && q.tbl[0].en |=> $stable(q.sequencer_function_select))
    else $error("sequencer select changed while enabled");

  enable_config_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == 4'h5 && !q.tbl[0].en && regReq.wrData[0]
      |=> q.tbl[0].en && q.tbl[0].output_filter_select == $past(regReq.wrData[5:4]))
    else $error("enabling write did not load fields");

  disable_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == 4'h5 && q.tbl[0].en && !regReq.wrData[0]
      |=> !q.tbl[0].en && $stable(q.tbl[0].output_filter_select))
    else $error("disabling write changed fields");

  global_enable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == glu_pkg::ADDR_CTRL |=> q.glbEn == $past(regReq.wrData[0]))
    else $error("global enable not written");

  table_enable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.wr && regReq.addr == 4'h9 |=> q.tbl[1].en == $past(regReq.wrData[0]))
    else $error("table enable not written");

  truth_out_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    te[1] && q.tbl[1].output_filter_select == glu_pkg::FILT_NONE && !q.tbl[1].edge_detect_enable
      |=> tableOut[1] == $past(lutVal[1]))
    else $error("table output does not follow truth lookup");

  read_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    regReq.rd && regReq.addr == 4'h8 |=> regRdData == $past(q.tbl[0].truth)
      ##1 regRdData == 8'h00 || $past(regReq.rd))
    else $error("read data wrong or held too long");

  seq_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !te[0] |=> !seqOut)
    else $error("sequencer not cleared by even disable");

  jk_toggle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    te[0] && q.sequencer_function_select == glu_pkg::SEQ_JK && tick[0] && pathOut[0] && pathOut[1]
      |=> seqOut != $past(seqOut))
    else $error("JK toggle failed");

  dff_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    te[0] && q.sequencer_function_select == glu_pkg::SEQ_DFF && !pathOut[1] |=> $stable(seqOut))
    else $error("gated D flop changed with gate low");

  jk_cover_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    te[0] && q.sequencer_function_select == glu_pkg::SEQ_JK && $rose(seqOut));
  rs_cover_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    te[0] && q.sequencer_function_select == glu_pkg::SEQ_RSLATCH && $fell(seqOut));
  clk_src_cover_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    te[1] && q.tbl[1].table_clock_source && tick[1]);
endmodule

/* File: verification/glu_far_side.sv */
// Far-side model: table pins, event lines and peripheral levels
`timescale 1ns/10ps
module glu_far_side (
  input wire logic ref_clk,
  output logic [glu_pkg::PIN_COUNT-1:0] tableInputPin,
  output logic eventLineA,
  output logic eventLineB,
  output logic [glu_pkg::PERIPH_COUNT-1:0] periphIn
);
  // All sources start low so no table sees an unknown
  initial begin
    tableInputPin = '0;
    eventLineA = 1'b0;
    eventLineB = 1'b0;
    periphIn = '0;
  end

  // A source changes just after an edge; pins and events are async to the unit
  task automatic drive(input logic [3:0] code, input int idx, input logic v);
    @(posedge ref_clk);
    case (code)
      glu_pkg::SRC_EVENT_A: eventLineA <= v;
      glu_pkg::SRC_EVENT_B: eventLineB <= v;
      glu_pkg::SRC_PIN: tableInputPin[idx] <= v;
      default: periphIn[idx] <= v;
    endcase
  endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the glue logic unit
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  glu_pkg::glu_reg_req_t regReq = '0;
  logic [7:0] regRdData;
  logic [glu_pkg::PIN_COUNT-1:0] tableInputPin;
  logic eventLineA;
  logic eventLineB;
  logic [glu_pkg::PERIPH_COUNT-1:0] periphIn;
  logic [glu_pkg::NUM_TABLES-1:0] tableOut;
  logic [glu_pkg::NUM_TABLES-1:0] tableOutEn;
  logic seqOut;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int hits;
  logic [11:0] pat;
  logic prevQ;
  logic [3:0] codes [3] = '{glu_pkg::SRC_EVENT_A, glu_pkg::SRC_EVENT_B, glu_pkg::SRC_PIN};

  always #2 ref_clk = ~ref_clk;

  glu_logic_unit u_glu_logic_unit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .regReq(regReq),
    .regRdData(regRdData),
    .tableInputPin(tableInputPin),
    .eventLineA(eventLineA),
    .eventLineB(eventLineB),
    .periphIn(periphIn),
    .tableOut(tableOut),
    .tableOutEn(tableOutEn),
    .seqOut(seqOut)
  );

  glu_far_side u_glu_far_side (
    .ref_clk(ref_clk),
    .tableInputPin(tableInputPin),
    .eventLineA(eventLineA),
    .eventLineB(eventLineB),
    .periphIn(periphIn)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    #1;
    chk(regRdData, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic count_high(input int n, output int k);
    k = 0;
    repeat (n) begin
      cyc(1);
      if (tableOut[0] === 1'b1) k++;
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the sequence needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    // Whole map reads zero after reset, unmapped space stays zero
    for (int a = 0; a < 16; a++) rdc(a[3:0], 8'h00, "reset value");
    wr(4'h3, 8'hff);
    rdc(4'h3, 8'h00, "unmapped");
    // Protection of the pair while table 0 runs
    wr(4'h5, 8'h09);
    rdc(4'h5, 8'h09, "enable loads fields");
    wr(4'h6, 8'h66);
    rdc(4'h6, 8'h00, "ctrlB locked");
    wr(4'h1, 8'h02);
    rdc(4'h1, 8'h00, "seq locked");
    wr(4'h9, 8'h31);
    rdc(4'h9, 8'h01, "odd enable free");
    wr(4'h9, 8'h00);
    wr(4'h5, 8'h00);
    rdc(4'h5, 8'h08, "disable keeps fields");
    // Lookup over all eight input codes from peripheral levels
    wr(4'h6, 8'h76);
    wr(4'h7, 8'h08);
    wr(4'h8, 8'h42);
    wr(4'h0, 8'h01);
    wr(4'h5, 8'h09);
    cyc(2);
    chk(tableOutEn, 2'b01, "out enable");
    for (int k = 0; k < 8; k++) begin
      for (int b = 0; b < 3; b++) u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, b, k[b]);
      cyc(2);
      chk(tableOut[0], 8'h42 >> k & 8'h01, "lookup");
    end
    wr(4'h0, 8'h00);
    cyc(3);
    chk({tableOut, tableOutEn}, 4'h0, "global off");
    wr(4'h0, 8'h01);
    wr(4'h5, 8'h08);
    cyc(3);
    chk({tableOut, tableOutEn}, 4'h0, "table off");
    // Masked input 0 reads low although its peripheral is high
    wr(4'h6, 8'h70);
    wr(4'h8, 8'h40);
    wr(4'h5, 8'h09);
    cyc(3);
    chk(tableOut[0], 8'h01, "masked");
    // Event and pin sources on table 1 input 0
    wr(4'h5, 8'h08);
    wr(4'hc, 8'h02);
    wr(4'h9, 8'h01);
    foreach (codes[i]) begin
      wr(4'ha, {4'h0, codes[i]});
      for (int v = 1; v >= 0; v--) begin
        u_glu_far_side.drive(codes[i], 3, v[0]);
        cyc(4);
        chk(tableOut[1], v[7:0], "source");
      end
    end
    // Link: table 1 follows table 0, which sees inputs 110
    wr(4'ha, 8'h02);
    wr(4'h5, 8'h01);
    cyc(4);
    chk(tableOut[1], 8'h01, "link high");
    wr(4'h8, 8'h00);
    cyc(4);
    chk(tableOut[1], 8'h00, "link low");
    // Sequencer modes; odd truth written first so no stray combination clocks in
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'ha, 8'h00);
    for (int m = 1; m < 5; m++) begin
      wr(4'h5, 8'h00);
      cyc(2);
      chk(seqOut, 8'h00, "disable clears");
      wr(4'h1, m[7:0]);
      wr(4'h5, 8'h01);
      pat = m[0] ? 12'b111_001_010_100 : 12'b101_001_010_000;
      for (int s = 3; s >= 0; s--) begin
        wr(4'hc, {7'h00, pat[3*s+1]});
        wr(4'h8, {7'h00, pat[3*s+2]});
        cyc(4);
        chk(seqOut, {7'h00, pat[3*s]}, "seq step");
      end
    end
    // JK with both inputs high toggles on every edge
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'h5, 8'h01);
    wr(4'hc, 8'h01);
    wr(4'h8, 8'h01);
    cyc(1);
    prevQ = seqOut;
    cyc(1);
    chk(seqOut, {7'h00, ~prevQ}, "toggle");
    // Feedback: RS latch reset by its own output through table 1
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h04);
    wr(4'ha, 8'h01);
    wr(4'hc, 8'h02);
    wr(4'h5, 8'h01);
    cyc(4);
    chk({seqOut, tableOut[1]}, 8'h03, "feedback set");
    wr(4'h8, 8'h00);
    cyc(5);
    chk({seqOut, tableOut[1]}, 8'h00, "feedback clear");
    // Synchronizer lag on a peripheral input
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h6, 8'h06);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h02);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b0);
    wr(4'h5, 8'h11);
    cyc(4);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b1);
    cyc(2);
    chk(tableOut[0], 8'h00, "sync early");
    cyc(1);
    chk(tableOut[0], 8'h01, "sync due");
    // Glitch filter drops a two-cycle pulse and lags a steady level
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b0);
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h21);
    cyc(8);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b1);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b1);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b0);
    count_high(10, hits);
    chk(hits[7:0], 8'h00, "glitch dropped");
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b1);
    cyc(4);
    chk(tableOut[0], 8'h00, "filter early");
    cyc(1);
    chk(tableOut[0], 8'h01, "filter due");
    // Edge detector behind the synchronizer gives one single-cycle pulse
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b0);
    wr(4'h5, 8'h00);
    wr(4'h5, 8'h91);
    cyc(8);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 0, 1'b1);
    count_high(12, hits);
    chk(hits[7:0], 8'h01, "edge pulse");
    // Clock-source bit: input 2 is high but indexes as low, so 001 selects bit 1
    wr(4'h5, 8'h00);
    wr(4'h7, 8'h08);
    wr(4'h8, 8'h02);
    u_glu_far_side.drive(glu_pkg::SRC_PERIPH_BASE, 2, 1'b1);
    wr(4'h5, 8'h41);
    cyc(3);
    chk(tableOut[0], 8'h01, "clock source low");
    end_of_test();
  end
endmodule
